// file: rtl/rcd_cmd_path.sv
// Command path: power-down sequencing, output inversion, control words.
// Assumes a clock-stop detector upstream raises clockStopped.
`timescale 1ns/100ps
`default_nettype none
`include "rcd_cmd_map.svh"
module rcd_cmd_path
#(
    parameter int ADDR_W = 16
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Mode straps and state indications
    input  wire logic              quad_select_enable_n,
    input  wire logic              clockStopped,
    input  wire logic              cke_pd_exit,
    // Host command bus
    input  wire logic [3:0]        chip_select_in_n,
    input  wire logic [1:0]        clock_enable_in,
    input  wire logic [1:0]        odt_in,
    input  wire logic              row_strobe_in_n,
    input  wire logic              column_strobe_in_n,
    input  wire logic              write_enable_in_n,
    input  wire logic [ADDR_W-1:0] address_in,
    input  wire logic [2:0]        bank_address_in,
    input  wire logic              parity_in,
    // A-side outputs
    output logic [3:0]             chip_select_out_n,
    output logic [1:0]             clock_enable_out,
    output logic [1:0]             odt_out,
    output logic                   row_strobe_out_n,
    output logic                   column_strobe_out_n,
    output logic                   write_enable_out_n,
    output logic [ADDR_W-1:0]      a_side_address_out,
    output logic [2:0]             a_side_bank_out,
    // B-side outputs
    output logic [ADDR_W-1:0]      b_side_address_out,
    output logic [2:0]             b_side_bank_out,
    // Output enable, receiver enable, error
    output logic                   outputsDriven,
    output logic                   receiversOn,
    output logic                   error_out_n,
    // Control word state
    output logic                   inversionActive,
    output logic [63:0]            controlWords
);
    // =========================================================
    // Input sampling
    // =========================================================
    logic [3:0]        csIn_r;       // Sampled selects
    logic [1:0]        ckeIn_r;      // Sampled clock enables
    logic [1:0]        odtIn_r;      // Sampled termination
    logic              rasIn_r;      // Sampled row strobe
    logic              casIn_r;      // Sampled column strobe
    logic              weIn_r;       // Sampled write enable
    logic [ADDR_W-1:0] addrIn_r;     // Sampled address
    logic [2:0]        bankIn_r;     // Sampled bank
    logic              parIn_r;      // Sampled parity
    logic              quadEn_r;     // Quad select mode
    logic              parityBad;    // Parity fault, aligned with the sampled inputs

    // Register every command input once
    always_ff @(posedge clk)
    begin
        csIn_r   <= chip_select_in_n;
        ckeIn_r  <= clock_enable_in;
        odtIn_r  <= odt_in;
        rasIn_r  <= row_strobe_in_n;
        casIn_r  <= column_strobe_in_n;
        weIn_r   <= write_enable_in_n;
        addrIn_r <= address_in;
        bankIn_r <= bank_address_in;
        parIn_r  <= parity_in;
        quadEn_r <= ~quad_select_enable_n;
    end

    // Parity checker
    rcd_parity_check #(.ADDR_W(ADDR_W)) parityChk
    (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .address      (address_in),
        .bank         (bank_address_in),
        .rowStrobeN   (row_strobe_in_n),
        .columnStrobeN(column_strobe_in_n),
        .writeEnableN (write_enable_in_n),
        .parity       (parity_in),
        .parityBad    (parityBad)
    );

    // =========================================================
    // Decoding
    // =========================================================
    // Count of asserted selects
    function automatic logic [2:0] lowCount(input logic [3:0] cs);
        lowCount = 3'({2'b0, ~cs[0]} + {2'b0, ~cs[1]} + {2'b0, ~cs[2]} + {2'b0, ~cs[3]});
    endfunction

    wire logic [3:0] csUsed   = quadEn_r ? csIn_r : {2'b11, csIn_r[1:0]};
    wire logic [2:0] csLows   = lowCount(csUsed);
    // R15: control word access combinations
    wire logic cwAccess = quadEn_r ? (csUsed == 4'h0 || csUsed == 4'h3)
                                   : (csUsed[1:0] == 2'h0);
    wire logic oneSel   = (csLows == 3'h1);
    // R12: mode-register-set decode
    wire logic mrsCmd   = oneSel && !rasIn_r && !casIn_r && !weIn_r;
    // R18: word select and data fields
    wire logic [3:0] cwIndex = {bankIn_r[2], addrIn_r[`RCD_SEL_ADDR_LSB +: 3]};
    wire logic [3:0] cwData  = {bankIn_r[1:0], addrIn_r[`RCD_DATA_ADDR_LSB +: 2]};
    wire logic upperZero     = (addrIn_r[ADDR_W-1:`RCD_UPPER_ADDR_LSB] == '0);
    // R19: valid only with upper address low, at least one clock enable high
    wire logic cwValid = cwAccess && upperZero && (ckeIn_r != 2'h0);

    // =========================================================
    // Power-down sequencing
    // =========================================================
    rcd_cmd_pkg::pd_state_t state_r;
    rcd_cmd_pkg::pd_state_t state_nxt;
    logic [3:0]             resumeCnt_r;  // Cycles since clock returned

    // Next-state selection
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            rcd_cmd_pkg::ST_RUN:
                state_nxt = clockStopped ? rcd_cmd_pkg::ST_STOPPED
                          : (cke_pd_exit ? rcd_cmd_pkg::ST_EXIT : rcd_cmd_pkg::ST_RUN);
            rcd_cmd_pkg::ST_STOPPED:
                if (!clockStopped)
                    state_nxt = rcd_cmd_pkg::ST_RESUME;
            rcd_cmd_pkg::ST_RESUME:
                if (resumeCnt_r == `RCD_RESUME_CYCLES)
                    state_nxt = rcd_cmd_pkg::ST_RUN;
            rcd_cmd_pkg::ST_EXIT:
                state_nxt = rcd_cmd_pkg::ST_RUN;
            default:
                state_nxt = rcd_cmd_pkg::ST_RUN;
        endcase
    end

    // State and resume counter
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r     <= rcd_cmd_pkg::ST_RUN;
            resumeCnt_r <= 4'h0;
        end
        else
        begin
            state_r     <= state_nxt;
            resumeCnt_r <= (state_r == rcd_cmd_pkg::ST_RESUME) ? resumeCnt_r + 4'h1 : 4'h0;
        end
    end

    wire logic stopped = (state_r == rcd_cmd_pkg::ST_STOPPED);
    wire logic running = (state_r == rcd_cmd_pkg::ST_RUN) || (state_r == rcd_cmd_pkg::ST_EXIT);

    // =========================================================
    // Mode-register-set timing and inversion
    // =========================================================
    logic [1:0] holdCnt_r;   // Three-cycle hold remaining
    logic       mrsSelPend_r; // Delayed select of an MRS
    logic [3:0] mrsCs_r;      // Select pattern of the MRS

    // R14: window counter re-enables inversion after three clocks
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            holdCnt_r <= 2'h0;
        else if (running && mrsCmd)
            // Loaded one short: the loading edge is the first held cycle
            holdCnt_r <= `RCD_MRS_HOLD - 2'h1;
        else if (holdCnt_r != 2'h0)
            holdCnt_r <= holdCnt_r - 2'h1;
    end

    // R12: remember select for one extra clock of delay
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mrsSelPend_r <= 1'b0;
            mrsCs_r      <= 4'hF;
        end
        else
        begin
            mrsSelPend_r <= running && mrsCmd;
            mrsCs_r      <= csUsed;
        end
    end

    // R11: new command loads outputs unless a hold is running
    wire logic holding  = (holdCnt_r != 2'h0) && !mrsCmd;
    wire logic loadCmd  = running && !cwAccess && !holding;

    // =========================================================
    // Control words
    // =========================================================
    // R21: write taken only when parity is good
    wire logic cwWrite = running && cwValid && !parityBad;

    // R23: reset defaults; R24: stop keeps contents; R22: any timing
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            controlWords        <= {16{`RCD_WORD_RESET}};
            controlWords[27:24] <= `RCD_WORD6_RESET;
            controlWords[31:28] <= `RCD_WORD7_RESET;
        end
        else if (cwWrite)
            controlWords[cwIndex*4 +: 4] <= cwData;
    end

    // R21: error flag on every bad control word write
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            error_out_n <= 1'b1;
        else
            error_out_n <= !(running && cwValid && parityBad);
    end

    // R9: inversion on from reset, gated off while MRS window open
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            inversionActive <= 1'b1;
        else
            inversionActive <= !((running && mrsCmd) || holding);
    end

    // =========================================================
    // Output stage
    // =========================================================
    wire logic [ADDR_W-1:0] invAddr = ADDR_W'(`RCD_ADDR_INV_MASK);
    wire logic invNext = !((running && mrsCmd) || holding);

    // R4/R25: receivers and outputs off in clock-stopped state
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            outputsDriven <= 1'b0;
            receiversOn   <= 1'b0;
        end
        else
        begin
            outputsDriven <= !stopped && state_nxt != rcd_cmd_pkg::ST_STOPPED;
            receiversOn   <= state_nxt != rcd_cmd_pkg::ST_STOPPED;
        end
    end

    // Selects: R8 exit hold, R17 control access, R12 delay
    always_ff @(posedge clk)
    begin
        if (sys_rst || !running)
            chip_select_out_n <= 4'hF;
        // R8: held high on power-down exit
        else if (state_r == rcd_cmd_pkg::ST_EXIT)
            chip_select_out_n <= 4'hF;
        // R17: all selects high on control access
        else if (cwAccess)
            chip_select_out_n <= 4'hF;
        // R12: MRS select issued one clock late
        else if (mrsSelPend_r)
            chip_select_out_n <= mrsCs_r;
        else if (mrsCmd)
            chip_select_out_n <= 4'hF;
        else
            chip_select_out_n <= csUsed;
    end

    // Clock enable and termination; R25 clock enables low when stopped
    always_ff @(posedge clk)
    begin
        if (sys_rst || stopped)
        begin
            clock_enable_out <= 2'h0;
            odt_out          <= 2'h0;
        end
        // R17/R20: hold on control access, odt ignored
        else if (!cwAccess)
        begin
            clock_enable_out <= ckeIn_r;
            odt_out          <= odtIn_r;
        end
    end

    // R6/R11/R10: gated command and address, B side from the same sampled inputs as A side
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            row_strobe_out_n    <= 1'b1;
            column_strobe_out_n <= 1'b1;
            write_enable_out_n  <= 1'b1;
            a_side_address_out  <= '0;
            a_side_bank_out     <= 3'h0;
            b_side_address_out  <= '0;
            b_side_bank_out     <= 3'h0;
        end
        else if (loadCmd)
        begin
            row_strobe_out_n    <= rasIn_r;
            column_strobe_out_n <= casIn_r;
            write_enable_out_n  <= weIn_r;
            a_side_address_out  <= addrIn_r;
            a_side_bank_out     <= bankIn_r;
            // R9/R10: complement listed bits only while inverting
            b_side_address_out  <= invNext ? (addrIn_r ^ invAddr) : addrIn_r;
            b_side_bank_out     <= invNext ? (bankIn_r ^ `RCD_BANK_INV_MASK) : bankIn_r;
        end
    end
endmodule
`default_nettype wire

// file: shared/rcd_cmd_map.svh
// Constants for the registering clock driver command path.
// Assumes inclusion by bare name from design and bench files.
//
// Summary of operation
// R1: Host enters clock-enable power-down before stopping clocks
// R2: Host holds clocks low before floating them
// R3: Host holds clock enable stable after clocks stop
// R4: Clock-stopped state disables receivers except clock
// R5: Host raises selects, lowers clock enable before wake
// R6: Outputs follow inputs soon after clock resumes
// R7: Host keeps selects steady during stabilisation time
// R8: Selects held high one cycle on power-down exit
// R9: Inversion on after reset; listed B bits complemented
// R10: Inversion off makes A and B sides equal
// R11: Three-cycle timing holds command three cycles
// R12: Mode-register-set disables inversion, delays select one cycle
// R13: Host spaces mode-register-set commands three cycles apart
// R14: Inversion returns three clocks after last mode-register-set
// R15: Control word access decoded from select combinations
// R16: Host never asserts exactly three of four selects
// R17: Control word access holds outputs, selects high
// R18: Sixteen four-bit words, address and data fields
// R19: Host keeps upper address low, clock enable high
// R20: Strobes and termination inputs ignored on control access
// R21: Parity error flags error and drops write
// R22: Control writes accepted under any timing setting
// R23: Reset clears words except six and seven defaults
// R24: Clock-stopped state keeps control words intact
// R25: Clock-stopped state floats outputs, clock enables low
// R26: Even parity over address, bank, strobes and parity
`ifndef RCD_CMD_MAP_SVH
`define RCD_CMD_MAP_SVH

// Address bits that the B side inverts (3-9, 11, 13-15)
`define RCD_ADDR_INV_MASK   16'hEBF8
// Bank bits that the B side inverts
`define RCD_BANK_INV_MASK   3'h7
// Default of vendor words six and seven (arbitrary value)
`define RCD_WORD6_RESET     4'h0
`define RCD_WORD7_RESET     4'h0
// Reset value of the other words
`define RCD_WORD_RESET      4'h0
// Three-cycle hold and inversion re-enable window
`define RCD_MRS_HOLD        2'h3
// Resume count that ends the resume state (nine cycles in it)
`define RCD_RESUME_CYCLES   4'h8
// Field positions of control word address and data
`define RCD_SEL_ADDR_LSB    0
`define RCD_DATA_ADDR_LSB   3
`define RCD_UPPER_ADDR_LSB  5

`endif

// file: shared/rcd_cmd_pkg.sv
// Types for the registering clock driver command path.
// Assumes the map header supplies all numeric constants.
package rcd_cmd_pkg;
    // Sequencing state of the output stage
    typedef enum logic [3:0]
    {
        ST_RUN     = 4'h1,
        ST_STOPPED = 4'h2,
        ST_RESUME  = 4'h4,
        ST_EXIT    = 4'h8
    } pd_state_t;
endpackage

// file: rtl/rcd_parity_check.sv
// Even-parity checker over the command and address inputs.
// Assumes inputs come unregistered from the caller's clock domain.
`timescale 1ns/100ps
`default_nettype none
module rcd_parity_check
#(
    parameter int ADDR_W = 16
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Unregistered command bus
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic [2:0]        bank,
    input  wire logic              rowStrobeN,
    input  wire logic              columnStrobeN,
    input  wire logic              writeEnableN,
    input  wire logic              parity,
    // Registered parity fault
    output logic                   parityBad
);
    // R26: odd count of ones is a fault
    wire logic oddOnes = ^{address, bank, rowStrobeN, columnStrobeN, writeEnableN, parity};

    // Register the result
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            parityBad <= 1'b0;
        else
            parityBad <= oddOnes;
    end
endmodule
`default_nettype wire

// file: verification/rcd_cmd_path_sva.sv
// Concurrent checks on the command path outputs.
// Assumes it is bound onto rcd_cmd_path and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "rcd_cmd_map.svh"
module rcd_cmd_path_sva
#(
    parameter int ADDR_W = 16
)
(
    // Clock, reset, state inputs
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              clockStopped,
    input wire logic              cke_pd_exit,
    // Observed outputs
    input wire logic [3:0]        chip_select_out_n,
    input wire logic [1:0]        clock_enable_out,
    input wire logic [1:0]        odt_out,
    input wire logic [ADDR_W-1:0] a_side_address_out,
    input wire logic [2:0]        a_side_bank_out,
    input wire logic [ADDR_W-1:0] b_side_address_out,
    input wire logic [2:0]        b_side_bank_out,
    input wire logic              outputsDriven,
    input wire logic              receiversOn,
    input wire logic              error_out_n,
    input wire logic              inversionActive,
    input wire logic [63:0]       controlWords
);
    // =========================================
    // Sequences
    localparam int RESUME_MAX = 12;   // Resume bound with margin
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Select high, low one cycle, high again
    sequence selPulse;
        (&chip_select_out_n) ##1 !(&chip_select_out_n) ##1 (&chip_select_out_n);
    endsequence
    // Address held for two more cycles
    sequence heldTwo;
        $stable(a_side_address_out)[*2];
    endsequence
    // =========================================
    // Assertions
    inv_on_a: assert property ((inversionActive && outputsDriven && $past(outputsDriven)) |->
        (b_side_address_out == (a_side_address_out ^ `RCD_ADDR_INV_MASK))
        && (b_side_bank_out == (a_side_bank_out ^ `RCD_BANK_INV_MASK))) else $error("B side not inverted");
    inv_off_a: assert property ((!inversionActive && outputsDriven) |->
        (b_side_address_out == a_side_address_out) && (b_side_bank_out == a_side_bank_out))
        else $error("B side differs from A side");
    mrs_hold_a: assert property ($fell(inversionActive) |-> ##1 heldTwo)
        else $error("Mode command not held three cycles");
    mrs_select_a: assert property ($fell(inversionActive) |-> selPulse)
        else $error("Mode command select not delayed");
    inv_return_a: assert property ($rose(inversionActive) |-> !$past(inversionActive, 3))
        else $error("Inversion returned early");
    word_quiet_a: assert property ($changed(controlWords) |-> (&chip_select_out_n)
        && $stable(a_side_address_out) && $stable(clock_enable_out) && $stable(odt_out))
        else $error("Outputs moved on control access");
    bad_write_a: assert property (!error_out_n |-> $stable(controlWords) ##1 error_out_n)
        else $error("Bad parity write not dropped");
    stop_float_a: assert property ($rose(clockStopped) |-> ##[1:4]
        (!outputsDriven && !receiversOn && clock_enable_out == 2'h0))
        else $error("Stopped state not entered");
    resume_a: assert property ($fell(clockStopped) |-> ##[1:RESUME_MAX] outputsDriven)
        else $error("Outputs not resumed");
    exit_sel_a: assert property (cke_pd_exit |-> ##[1:2] (&chip_select_out_n))
        else $error("Selects not high on exit");
    stop_keep_a: assert property (clockStopped |-> $stable(controlWords))
        else $error("Words changed while stopped");
endmodule
bind rcd_cmd_path rcd_cmd_path_sva #(.ADDR_W(ADDR_W)) rcd_cmd_path_sva_i (.clk(clk),
    .sys_rst(sys_rst), .clockStopped(clockStopped), .cke_pd_exit(cke_pd_exit),
    .chip_select_out_n(chip_select_out_n), .clock_enable_out(clock_enable_out),
    .odt_out(odt_out), .a_side_address_out(a_side_address_out),
    .a_side_bank_out(a_side_bank_out), .b_side_address_out(b_side_address_out),
    .b_side_bank_out(b_side_bank_out), .outputsDriven(outputsDriven),
    .receiversOn(receiversOn), .error_out_n(error_out_n),
    .inversionActive(inversionActive), .controlWords(controlWords));
`default_nettype wire

// file: verification/rcd_host_model.sv
// Memory controller model driving the command bus at falling edges.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/100ps
`default_nettype none
module rcd_host_model
(
    // Clock
    input wire logic   clk,
    // Command bus
    output logic [3:0]  csN,
    output logic [1:0]  ckeIn,
    output logic [1:0]  odtIn,
    output logic [2:0]  strobeN,
    output logic [15:0] addr,
    output logic [2:0]  bank,
    output logic        par,
    // Clock-stop indication and exit pulse
    output logic        stopped,
    output logic        pdExit
);
    // =========================================
    // Idle bus at time zero
    initial
    begin
        csN     = 4'hF;
        ckeIn   = 2'h3;
        odtIn   = 2'h0;
        strobeN = 3'h7;
        addr    = 16'h0000;
        bank    = 3'h0;
        // Even parity over three high strobes
        par     = 1'b1;
        stopped = 1'b0;
        pdExit  = 1'b0;
    end
    // One command cycle, then deselect with a changed bus
    // even parity, bad flips it
    task send(input logic [3:0] cs, input logic [2:0] st, input logic [15:0] a,
              input logic [2:0] b, input logic bad);
        @(negedge clk);
        csN = cs;
        strobeN = st;
        addr = a;
        bank = b;
        par = ^{a, b, st} ^ bad;
        odtIn = ~odtIn;
        @(negedge clk);
        csN = 4'hF;
        strobeN = 3'h7;
        addr = ~addr;
        par = ^{addr, bank, strobeN};
    endtask
    // Clock-stop entry, wake and clock-enable exit
    task clockStop();
        @(negedge clk);
        ckeIn = 2'h0;
        repeat (2) @(negedge clk);
        stopped = 1'b1;
        repeat (4) @(negedge clk);
        addr = 16'hA5A5;
        repeat (4) @(negedge clk);
        // selects high, enable low at wake
        stopped = 1'b0;
        repeat (16) @(negedge clk);
        ckeIn = 2'h1;
        csN = 4'hE;
        pdExit = 1'b1;
        @(negedge clk);
        pdExit = 1'b0;
        csN = 4'hF;
    endtask
endmodule
`default_nettype wire

// file: verification/rcd_cmd_path_test.sv
// Self-checking bench for the command path.
// Assumes the host model and bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "rcd_cmd_map.svh"
module rcd_cmd_path_test;
    // =========================================
    // Signals
    logic clk, sys_rst, quadN;        // Clock, reset, quad strap
    logic [3:0] csN, csOut;           // Selects in and out
    logic [1:0] ckeIn, odtIn;         // Enables in
    logic [2:0] strobeN, strobeOut, bank, bBank; // Strobes, banks
    logic [15:0] addr, aAddr, bAddr;  // Address in and out
    logic par, stopped, pdExit, errN, inv;
    logic [63:0] words, expWords;     // Control words, model
    int errors, checked;
    rcd_host_model rcd_host_model_i (.clk(clk), .csN(csN), .ckeIn(ckeIn), .odtIn(odtIn),
        .strobeN(strobeN), .addr(addr), .bank(bank), .par(par), .stopped(stopped), .pdExit(pdExit));
    rcd_cmd_path rcd_cmd_path_i (.clk(clk), .sys_rst(sys_rst), .quad_select_enable_n(quadN),
        .clockStopped(stopped), .cke_pd_exit(pdExit), .chip_select_in_n(csN),
        .clock_enable_in(ckeIn), .odt_in(odtIn), .row_strobe_in_n(strobeN[2]),
        .column_strobe_in_n(strobeN[1]), .write_enable_in_n(strobeN[0]), .address_in(addr),
        .bank_address_in(bank), .parity_in(par), .chip_select_out_n(csOut),
        .clock_enable_out(), .odt_out(), .row_strobe_out_n(strobeOut[2]),
        .column_strobe_out_n(strobeOut[1]),
        .write_enable_out_n(strobeOut[0]), .a_side_address_out(aAddr), .a_side_bank_out(),
        .b_side_address_out(bAddr), .b_side_bank_out(bBank), .outputsDriven(),
        .receiversOn(), .error_out_n(errN), .inversionActive(inv), .controlWords(words));
    // Clock at 5 ns
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // =========================================
    // Tasks
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Control word write, result settled on return
    task cw(input logic [3:0] cs, input logic [3:0] k, input logic [3:0] d, input logic bad);
        // upper address low, clock enables left unchanged, at least one high
        rcd_host_model_i.send(cs, {3{k[0]}}, {11'h0, d[1:0], k[2:0]}, {k[3], d[3:2]}, bad);
        @(negedge clk);
    endtask
    task rst();
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
    endtask
    task test_done();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #50000;
        errors++;
        test_done();
    end
    // =========================================
    // Main sequence
    initial
    begin
        {errors, checked, quadN, expWords} = {64'h0, 1'b1, 64'h0};
        rst();
        chk(words, 64'h0);
        chk(inv, 1'b1);
        $display("reset test done");
        rcd_host_model_i.send(4'hE, 3'h3, 16'h1234, 3'h5, 1'b0);
        @(negedge clk);
        chk(aAddr, 16'h1234);
        chk(bAddr, 16'h1234 ^ `RCD_ADDR_INV_MASK);
        chk(bBank, 3'h5 ^ `RCD_BANK_INV_MASK);
        chk(csOut, 4'hE);
        chk(strobeOut, 3'h3);
        $display("inversion test done");
        for (int k = 0; k < 16; k++)
        begin
            cw(4'hC, k[3:0], k[3:0] ^ 4'h9, 1'b0);
            expWords[4*k+:4] = k[3:0] ^ 4'h9;
            chk(csOut, 4'hF);
            chk(words, expWords);
        end
        cw(4'h3, 4'h1, 4'h3, 1'b0);
        chk(words, expWords);
        cw(4'hC, 4'h1, 4'h3, 1'b1);
        chk(errN, 1'b0);
        chk(words, expWords);
        $display("control word test done");
        rcd_host_model_i.send(4'hD, 3'h0, 16'h0A5C, 3'h6, 1'b0);
        @(negedge clk);
        chk(inv, 1'b0);
        chk(strobeOut, 3'h0);
        chk({bAddr, bBank}, {16'h0A5C, 3'h6});
        @(negedge clk);
        chk(csOut, 4'hD);
        @(negedge clk);
        chk(aAddr, 16'h0A5C);
        chk(inv, 1'b0);
        @(negedge clk);
        chk(inv, 1'b1);
        chk(aAddr, 16'hF5A3);
        $display("mode command test done");
        rcd_host_model_i.clockStop();
        chk(words, expWords);
        $display("power-down test done");
        quadN = 1'b0;
        rst();
        cw(4'h3, 4'h3, 4'h6, 1'b0);
        cw(4'h0, 4'hC, 4'hA, 1'b0);
        chk(words, 64'h000A_0000_0000_6000);
        $display("quad select test done");
        test_done();
    end
endmodule
`default_nettype wire
